// ### iir_pkg.sv
`default_nettype none
package iir_pkg;
  localparam int NUM_SRC = 32;
  localparam int NUM_CORE = 4;
  localparam int NUM_PIN = 4;
  // word indexes; byte address is four times the index
  localparam logic [29:0] IDX_RAW_STATUS = 30'h3FF01420;
  localparam logic [29:0] IDX_ENABLE_STATE = 30'h3FF01424;
  localparam logic [29:0] IDX_ENABLE_SETTER = 30'h3FF01428;
  localparam logic [29:0] IDX_ENABLE_CLEARER = 30'h3FF0142C;
  localparam logic [29:0] IDX_TRIGGER_SELECT = 30'h3FF01438;
  localparam logic [29:0] IDX_CORE_STATUS [NUM_CORE] = '{30'h3FF01440, 30'h3FF01448, 30'h3FF01450, 30'h3FF01458};
  localparam logic [29:0] IDX_EVT_STATUS = 30'h3FF01460;
  localparam logic [29:0] IDX_EVT_MASK = 30'h3FF01464;
  localparam logic [29:0] IDX_ROUTE [NUM_SRC] = '{
    30'h3FF01400, 30'h3FF01402, 30'h3FF01403, 30'h3FF01404, 30'h3FF01405, 30'h3FF01406, 30'h3FF01407, 30'h3FF01408,
    30'h3FF01409, 30'h3FF0140A, 30'h3FF0140B, 30'h3FF0140C, 30'h3FF0140D, 30'h3FF0140E, 30'h3FF0140F, 30'h3FF0140F,
    30'h3FF01410, 30'h3FF01411, 30'h3FF01412, 30'h3FF01413, 30'h3FF01414, 30'h3FF01415, 30'h3FF01416, 30'h3FF01417,
    30'h3FF01418, 30'h3FF01419, 30'h3FF0141A, 30'h3FF0141B, 30'h3FF0141C, 30'h3FF0141D, 30'h3FF0141E, 30'h3FF0141F};
  // slot 14 is reserved and shares its index with slot 15
  localparam logic [31:0] ROUTE_LIVE = 32'hFFFFBFFF;
  localparam int ROUTE_CORE_LSB = 0;
  localparam int ROUTE_PIN_LSB = 4;
  // trigger bits that software may change, and trigger reset value
  localparam logic [31:0] TRIG_WMASK = 32'hFFFFF80F;
  localparam logic [31:0] TRIG_RESET = 32'h00000600;
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [31:0] EVT_MASK_RESET = 32'h00000000;

  typedef logic [NUM_PIN-1:0] iir_pins_t;
  typedef iir_pins_t [NUM_CORE-1:0] iir_core_pins_t;

  typedef struct packed {
    logic [31:0] srcMeta;
    logic [31:0] srcSync;
    logic [31:0] srcPrev;
    logic [31:0] enable;
    logic [31:0] trig;
    logic [31:0] latched;
    logic [NUM_SRC-1:0][7:0] route;
    logic [31:0] evt;
    logic [31:0] evtMask;
    logic wrPend;
    logic [29:0] addrIdx;
    logic [31:0] rdata;
    iir_core_pins_t pins;
  } iir_state_t;
endpackage
`default_nettype wire

// ### io_interrupt_router.sv
`timescale 1ns/1ns
`default_nettype none
module io_interrupt_router (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interrupt sources, asynchronous
  input wire logic [31:0] srcIrq,
  // core pins, index 0 is status bit two
  output iir_pkg::iir_core_pins_t coreIrqPin,
  // summary interrupt
  output logic irqOut
);
  iir_pkg::iir_state_t stateReg;
  iir_pkg::iir_state_t stateNext;
  logic [31:0] pending;
  logic [31:0] active;
  logic [31:0] coreRouted [iir_pkg::NUM_CORE];
  logic [31:0] pinSel [iir_pkg::NUM_PIN];
  logic [31:0] rise;
  logic [31:0] setBits;
  logic [31:0] clrBits;
  logic [31:0] evtClr;
  logic addrTaken;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = stateReg.rdata;
  assign coreIrqPin = stateReg.pins;
  assign irqOut = |(stateReg.evt & stateReg.evtMask);
  assign addrTaken = hsel & htrans[1] & hready;
  assign rise = stateReg.srcSync & ~stateReg.srcPrev;

  // latched record for pulse sources, synced line for level ones
  assign pending = (stateReg.trig & stateReg.latched) | (~stateReg.trig & stateReg.srcSync);
  assign active = pending & stateReg.enable;

  genvar gc;
  genvar gi;
  generate
    for (gc = 0; gc < iir_pkg::NUM_CORE; gc++) begin : g_core
      for (gi = 0; gi < iir_pkg::NUM_SRC; gi++) begin : g_src
        assign coreRouted[gc][gi] = active[gi] & stateReg.route[gi][iir_pkg::ROUTE_CORE_LSB + gc];
        assign pinSel[gc][gi] = stateReg.route[gi][iir_pkg::ROUTE_PIN_LSB + gc];
      end
    end
  endgenerate

  // returns {hit, slot}; reserved slot never hits
  function automatic logic [5:0] routeSlot(input logic [29:0] idx);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 0; i < iir_pkg::NUM_SRC; i++) begin
      if (iir_pkg::ROUTE_LIVE[i] && idx == iir_pkg::IDX_ROUTE[i]) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] readWord(input logic [29:0] idx);
    logic [31:0] res;
    logic [5:0] slot;
    res = 32'h00000000;
    slot = routeSlot(idx);
    if (slot[5]) begin
      res = {24'h000000, stateReg.route[slot[4:0]]};
    end else if (idx == iir_pkg::IDX_RAW_STATUS) begin
      res = pending;
    end else if (idx == iir_pkg::IDX_ENABLE_STATE) begin
      res = stateReg.enable;
    end else if (idx == iir_pkg::IDX_TRIGGER_SELECT) begin
      res = stateReg.trig;
    end else if (idx == iir_pkg::IDX_EVT_STATUS) begin
      res = stateReg.evt;
    end else if (idx == iir_pkg::IDX_EVT_MASK) begin
      res = stateReg.evtMask;
    end else begin
      for (int c = 0; c < iir_pkg::NUM_CORE; c++) begin
        if (idx == iir_pkg::IDX_CORE_STATUS[c]) begin
          res = coreRouted[c];
        end
      end
    end
    return res;
  endfunction

  always_comb begin
    logic [5:0] slot;
    slot = routeSlot(stateReg.addrIdx);
    stateNext = stateReg;
    // two flops before any logic looks at a source
    stateNext.srcMeta = srcIrq;
    stateNext.srcSync = stateReg.srcMeta;
    stateNext.srcPrev = stateReg.srcSync;
    setBits = 32'h00000000;
    clrBits = 32'h00000000;
    evtClr = 32'h00000000;
    if (stateReg.wrPend) begin
      if (slot[5]) begin
        stateNext.route[slot[4:0]] = hwdata[7:0];
      end
      if (stateReg.addrIdx == iir_pkg::IDX_ENABLE_SETTER) begin
        setBits = hwdata;
      end
      if (stateReg.addrIdx == iir_pkg::IDX_ENABLE_CLEARER) begin
        clrBits = hwdata;
      end
      if (stateReg.addrIdx == iir_pkg::IDX_TRIGGER_SELECT) begin
        stateNext.trig = (hwdata & iir_pkg::TRIG_WMASK) | (stateReg.trig & ~iir_pkg::TRIG_WMASK);
      end
      if (stateReg.addrIdx == iir_pkg::IDX_EVT_STATUS) begin
        evtClr = hwdata;
      end
      if (stateReg.addrIdx == iir_pkg::IDX_EVT_MASK) begin
        stateNext.evtMask = hwdata;
      end
    end
    stateNext.enable = (stateReg.enable | setBits) & ~clrBits;
    // a fresh edge beats a clear in the same cycle
    stateNext.latched = (stateReg.latched & ~clrBits) | (rise & stateReg.trig);
    stateNext.evt = (stateReg.evt & ~evtClr) | rise;
    for (int c = 0; c < iir_pkg::NUM_CORE; c++) begin
      for (int p = 0; p < iir_pkg::NUM_PIN; p++) begin
        stateNext.pins[c][p] = |(coreRouted[c] & pinSel[p]);
      end
    end
    // zero wait states: read data captured in the address phase
    stateNext.wrPend = addrTaken & hwrite;
    if (addrTaken) begin
      stateNext.addrIdx = haddr[31:2];
      if (!hwrite) begin
        stateNext.rdata = readWord(haddr[31:2]);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stateReg <= '0;
      stateReg.enable <= iir_pkg::ENABLE_RESET;
      stateReg.trig <= iir_pkg::TRIG_RESET;
      stateReg.route <= {iir_pkg::NUM_SRC{iir_pkg::ROUTE_RESET}};
      stateReg.evtMask <= iir_pkg::EVT_MASK_RESET;
    end else begin
      stateReg <= stateNext;
    end
  end

  sequence wrPhase(logic [29:0] idx);
    stateReg.wrPend && stateReg.addrIdx == idx;
  endsequence

  sequence rdAddr(logic [29:0] idx);
    addrTaken && !hwrite && haddr[31:2] == idx;
  endsequence

  AST_EN_SET: assert property (@(posedge clk_sys) disable iff (reset)
    wrPhase(iir_pkg::IDX_ENABLE_SETTER) |=> ((stateReg.enable & $past(hwdata)) == $past(hwdata)))
    else $error("setter write did not enable bits");

  AST_EN_CLR: assert property (@(posedge clk_sys) disable iff (reset)
    wrPhase(iir_pkg::IDX_ENABLE_CLEARER) |=> ((stateReg.enable & $past(hwdata)) == 32'h00000000)
      && ((stateReg.enable & ~$past(hwdata)) == ($past(stateReg.enable) & ~$past(hwdata))))
    else $error("clearer write wrong");

  AST_EN_READ: assert property (@(posedge clk_sys) disable iff (reset)
    rdAddr(iir_pkg::IDX_ENABLE_STATE) |=> hrdata == $past(stateReg.enable))
    else $error("enable read mismatch");

  AST_PULSE_LATCH: assert property (@(posedge clk_sys) disable iff (reset)
    (|(rise & stateReg.trig)) |=> ((stateReg.latched & $past(rise & stateReg.trig)) == $past(rise & stateReg.trig)))
    else $error("pulse edge not latched");

  AST_PULSE_CLR: assert property (@(posedge clk_sys) disable iff (reset)
    wrPhase(iir_pkg::IDX_ENABLE_CLEARER) ##0 (rise == 32'h00000000) |=> ((stateReg.latched & $past(hwdata)) == 32'h00000000))
    else $error("latched event not dropped");

  AST_ROUTE_WR: assert property (@(posedge clk_sys) disable iff (reset)
    wrPhase(iir_pkg::IDX_ROUTE[3]) |=> stateReg.route[3] == $past(hwdata[7:0]))
    else $error("route slot write lost");

  AST_PIN_C3P2: assert property (@(posedge clk_sys) disable iff (reset)
    (|(active & pinSel[2] & coreRouted[3])) |=> coreIrqPin[3][2] ##1 (coreIrqPin[3][2] || !$past(|(coreRouted[3] & pinSel[2]))))
    else $error("routed pin not raised");

  AST_PIN_LOW: assert property (@(posedge clk_sys) disable iff (reset)
    (coreRouted[0] == 32'h00000000) [*2] |=> coreIrqPin[0] == 4'h0)
    else $error("pin high with nothing pending");

  AST_RAW_READ: assert property (@(posedge clk_sys) disable iff (reset)
    rdAddr(iir_pkg::IDX_RAW_STATUS) |=> hrdata == $past(pending))
    else $error("raw status read mismatch");

  // write-only words read back as zero
  AST_SETTER_READ: assert property (@(posedge clk_sys) disable iff (reset)
    rdAddr(iir_pkg::IDX_ENABLE_SETTER) |=> hrdata == 32'h00000000)
    else $error("setter read not zero");

  AST_CLEARER_READ: assert property (@(posedge clk_sys) disable iff (reset)
    rdAddr(iir_pkg::IDX_ENABLE_CLEARER) |=> hrdata == 32'h00000000)
    else $error("clearer read not zero");

  AST_ENSTATE_RO: assert property (@(posedge clk_sys) disable iff (reset)
    wrPhase(iir_pkg::IDX_ENABLE_STATE) |=> stateReg.enable == $past(stateReg.enable))
    else $error("enable state took a write");

  // enables only move on a setter or clearer data phase
  AST_EN_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    !stateReg.wrPend |=> stateReg.enable == $past(stateReg.enable))
    else $error("enable changed without a write");

  AST_TRIG_WR: assert property (@(posedge clk_sys) disable iff (reset)
    wrPhase(iir_pkg::IDX_TRIGGER_SELECT)
      |=> (stateReg.trig & iir_pkg::TRIG_WMASK) == ($past(hwdata) & iir_pkg::TRIG_WMASK))
    else $error("trigger write lost");

  // fixed trigger bits never follow software
  AST_TRIG_RO: assert property (@(posedge clk_sys) disable iff (reset)
    wrPhase(iir_pkg::IDX_TRIGGER_SELECT)
      |=> (stateReg.trig & ~iir_pkg::TRIG_WMASK) == ($past(stateReg.trig) & ~iir_pkg::TRIG_WMASK))
    else $error("fixed trigger bit changed");

  AST_LATCH_KEEP: assert property (@(posedge clk_sys) disable iff (reset)
    (rise == 32'h00000000 && !(stateReg.wrPend && stateReg.addrIdx == iir_pkg::IDX_ENABLE_CLEARER))
      |=> stateReg.latched == $past(stateReg.latched))
    else $error("latched record moved on its own");

  AST_ROUTE_READ: assert property (@(posedge clk_sys) disable iff (reset)
    rdAddr(iir_pkg::IDX_ROUTE[5]) |=> hrdata == {24'h000000, $past(stateReg.route[5])})
    else $error("route slot read mismatch");

  // reserved slot can never steer source 14
  AST_RSVD_SLOT: assert property (@(posedge clk_sys) disable iff (reset)
    stateReg.route[14] == iir_pkg::ROUTE_RESET)
    else $error("reserved route slot written");

  AST_CORE3_READ: assert property (@(posedge clk_sys) disable iff (reset)
    rdAddr(iir_pkg::IDX_CORE_STATUS[3]) |=> hrdata == $past(coreRouted[3]))
    else $error("core status read mismatch");

  AST_CORE0_READ: assert property (@(posedge clk_sys) disable iff (reset)
    rdAddr(iir_pkg::IDX_CORE_STATUS[0]) |=> hrdata == $past(coreRouted[0]))
    else $error("core status read mismatch");

  // nothing enabled and pending means every pin drops next edge
  AST_ALL_QUIET: assert property (@(posedge clk_sys) disable iff (reset)
    (active == 32'h00000000) |=> coreIrqPin == 16'h0000)
    else $error("pin high with no active source");

  AST_EVT_SET: assert property (@(posedge clk_sys) disable iff (reset)
    (|rise) |=> ((stateReg.evt & $past(rise)) == $past(rise)))
    else $error("source edge not recorded");

  AST_EVT_CLR: assert property (@(posedge clk_sys) disable iff (reset)
    wrPhase(iir_pkg::IDX_EVT_STATUS) ##0 (rise == 32'h00000000)
      |=> ((stateReg.evt & $past(hwdata)) == 32'h00000000))
    else $error("event bit not cleared");

  AST_MASK_WR: assert property (@(posedge clk_sys) disable iff (reset)
    wrPhase(iir_pkg::IDX_EVT_MASK) |=> stateReg.evtMask == $past(hwdata))
    else $error("event mask write lost");
endmodule // io_interrupt_router
`default_nettype wire

// ### iir_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module iir_core_model (
  // pins from the router
  input wire iir_pkg::iir_core_pins_t coreIrqPin,
  // status word interrupt bits seen by each core
  output logic [3:0][7:0] coreStatus
);
  // a core samples its pins as plain levels, so no latching here
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      coreStatus[c] = {2'b00, coreIrqPin[c], 2'b00};
    end
  end
endmodule // iir_core_model
`default_nettype wire

// ### io_interrupt_router_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module io_interrupt_router_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] srcIrq = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  iir_pkg::iir_core_pins_t coreIrqPin;
  logic irqOut;
  logic [3:0][7:0] coreStatus;
  logic [31:0] rd;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  io_interrupt_router io_interrupt_router_inst (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .srcIrq(srcIrq), .coreIrqPin(coreIrqPin), .irqOut(irqOut));
  iir_core_model iir_core_model_inst (.coreIrqPin(coreIrqPin), .coreStatus(coreStatus));
  always #50 clk_sys = ~clk_sys;
  // one ahb single transfer; byte address is four times the word index
  task automatic bus(input logic wr, input logic [29:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [29:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task automatic rdchk(input string n, input logic [29:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    `CHK(n, exp, rd)
    `CHK("hresp", 1'b0, hresp)
    `CHK("hreadyout", 1'b1, hreadyout)
  endtask
  // settle on a falling edge so registered outputs have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic t_reset;
    rdchk("enable", 30'h3FF01424, 32'h00000000);
    rdchk("route0", 30'h3FF01400, 32'h00000000);
    rdchk("trigger", 30'h3FF01438, iir_pkg::TRIG_RESET);
    rdchk("unmapped", 30'h3FF01470, 32'h00000000);
    `CHK("pins", 16'h0000, coreIrqPin)
    $display("test reset done");
  endtask
  task automatic t_enable;
    wr(30'h3FF01428, 32'h00008021);
    rdchk("enset", 30'h3FF01424, 32'h00008021);
    wr(30'h3FF01428, 32'h00000000);
    wr(30'h3FF0142C, 32'h00000001);
    rdchk("enclr", 30'h3FF01424, 32'h00008020);
    wr(30'h3FF01424, 32'hFFFFFFFF);
    rdchk("enro", 30'h3FF01424, 32'h00008020);
    $display("test enable done");
  endtask
  task automatic t_level;
    wr(30'h3FF01406, 32'h00000048);
    rdchk("route5", 30'h3FF01406, 32'h00000048);
    srcIrq[5] <= 1'b1;
    settle(5);
    `CHK("pin32", 16'h4000, coreIrqPin)
    `CHK("core3ip", 8'h10, coreStatus[3])
    rdchk("core3", 30'h3FF01458, 32'h00000020);
    rdchk("core0", 30'h3FF01440, 32'h00000000);
    wr(30'h3FF0142C, 32'h00000020);
    settle(3);
    `CHK("pinoff", 16'h0000, coreIrqPin)
    rdchk("raw", 30'h3FF01420, 32'h00000020);
    @(posedge clk_sys);
    srcIrq[5] <= 1'b0;
    wr(30'h3FF01428, 32'h00000020);
    settle(5);
    `CHK("pinlow", 16'h0000, coreIrqPin)
    $display("test level done");
  endtask
  task automatic t_pulse;
    wr(30'h3FF01438, 32'h00008000);
    rdchk("trig", 30'h3FF01438, 32'h00008600);
    wr(30'h3FF0140F, 32'h00000011);
    srcIrq[15] <= 1'b1;
    @(posedge clk_sys);
    srcIrq[15] <= 1'b0;
    settle(5);
    `CHK("latched", 16'h0001, coreIrqPin)
    rdchk("rawlat", 30'h3FF01420, 32'h00008000);
    wr(30'h3FF0142C, 32'h00008000);
    settle(3);
    `CHK("unlatched", 16'h0000, coreIrqPin)
    rdchk("rawclr", 30'h3FF01420, 32'h00000000);
    $display("test pulse done");
  endtask
  task automatic t_irq;
    // both sources rose once or more, whatever their enables
    rdchk("evt", 30'h3FF01460, 32'h00008020);
    `CHK("irqmasked", 1'b0, irqOut)
    wr(30'h3FF01464, 32'h00000020);
    settle(0);
    `CHK("irqon", 1'b1, irqOut)
    wr(30'h3FF01460, 32'h00000020);
    settle(0);
    `CHK("irqoff", 1'b0, irqOut)
    rdchk("evtclr", 30'h3FF01460, 32'h00008000);
    $display("test irq done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // whole run needs about 110 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_enable();
    t_level();
    t_pulse();
    t_irq();
    end_of_test();
  end
endmodule // io_interrupt_router_test
`default_nettype wire
